// >>> rtl/protect_pkg.sv
// Purpose: Shared constants and carriers for the protection block
// Assumes: 20 MHz core clock
// Notes: Register offsets are byte addresses on APB
package protect_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_HZ = 20000000;
  localparam int SLEEP_FILTER_US = 30;
  localparam int SLEEP_FILTER_CYC = (SLEEP_FILTER_US * (CLK_HZ / 1000000));
  localparam int BRAKE_CHOP_HZ = 3500;
  localparam int BRAKE_HALF_CYC = CLK_HZ / (2 * BRAKE_CHOP_HZ);
  localparam int OC_BLANK_CYC = 20;
  localparam int OC_RETRY_MAX = 3;
  localparam int OC_RETRY_WAIT_CYC = 200;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] GLOBAL_CONFIG_OFS = 8'h00;
  localparam logic [7:0] DRIVER_CONFIG_OFS = 8'h04;
  localparam logic [7:0] CHOPPER_CONFIG_OFS = 8'h08;
  localparam logic [7:0] THERMAL_LIMIT_OFS = 8'h0C;
  localparam logic [7:0] DRIVER_STATUS_OFS = 8'h10;
  localparam logic [7:0] SUPPLY_SAMPLE_OFS = 8'h14;
  localparam logic [7:0] TEMP_SAMPLE_OFS = 8'h18;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int STOP_ENABLE_BIT = 0;
  localparam int RANGE_LSB = 0;
  localparam int OFF_TIME_LSB = 0;
  localparam int SUPPLY_LIM_LSB = 0;
  localparam int WARN_LIM_LSB = 16;
  localparam logic [31:0] GLOBAL_CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] DRIVER_CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] CHOPPER_CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] THERMAL_LIMIT_RST = 32'h0000_0000;
  // Current thresholds in mA per range code
  localparam logic [12:0] OC_LIM_00 = 13'h0686;
  localparam logic [12:0] OC_LIM_01 = 13'h0D02;
  localparam logic [12:0] OC_LIM_1X = 13'h1388;
  // Temperature sample: 7.7 counts per degree plus offset
  localparam int TEMP_OFFSET = 2038;
  localparam int TEMP_SCALE_X10 = 77;
  localparam real SUPPLY_LSB_MV = 9.732;
  typedef struct packed {
    logic [12:0] current_a;
    logic [12:0] current_b;
    logic die_hot;
    logic die_cool;
    logic [12:0] supply_adc;
    logic [12:0] temp_adc;
  } sense_s;
  typedef enum logic [1:0] {
    BR_RUN = 2'b00,
    BR_RETRY = 2'b01,
    BR_LATCHED = 2'b10
  } bridge_state_e;
endpackage : protect_pkg

// >>> rtl/sleep_filter.sv
// Purpose: Synchronise and filter the sleep/reset pin
// Assumes: Pin is asynchronous to core_clk
// Notes: Pulse longer than the filter time asserts chip reset
`timescale 1ns/1ns
module sleep_filter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Pin and result
  input wire logic sleep_reset_n,
  output logic chip_reset
);
  logic sync1;
  logic sync2;
  logic [10:0] low_cnt;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else if (clk_en) begin
      sync1 <= sleep_reset_n;
      sync2 <= sync1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      low_cnt <= 11'h000;
      chip_reset <= 1'b0;
    end else if (clk_en) begin
      if (sync2) begin
        low_cnt <= 11'h000;
        chip_reset <= 1'b0;
      end else if (low_cnt < 11'(protect_pkg::SLEEP_FILTER_CYC)) begin
        low_cnt <= low_cnt + 11'h001;
      end else begin
        chip_reset <= 1'b1;
      end
    end
  end
endmodule : sleep_filter

// >>> rtl/bridge_guard.sv
// Purpose: Overcurrent blanking, retries and latch for one bridge
// Assumes: Current samples on core_clk
// Notes: Two to ground / supply flags by direction of fault
`timescale 1ns/1ns
module bridge_guard (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Sense
  input wire logic [12:0] current,
  input wire logic high_side,
  input wire logic [12:0] limit,
  input wire logic recover,
  // Result
  output logic bridge_off,
  output logic short_gnd,
  output logic short_supply
);
  protect_pkg::bridge_state_e state;
  logic [7:0] cnt;
  logic [1:0] tries;
  logic over;
  assign over = current > limit;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= protect_pkg::BR_RUN;
      cnt <= 8'h00;
      tries <= 2'h0;
      short_gnd <= 1'b0;
      short_supply <= 1'b0;
    end else if (clk_en) begin
      case (state)
        protect_pkg::BR_RUN: begin
          if (recover) begin
            tries <= 2'h0;
            cnt <= 8'h00;
          end else if (over) begin
            if (cnt >= 8'(protect_pkg::OC_BLANK_CYC)) begin
              cnt <= 8'h00;
              if (tries == 2'(protect_pkg::OC_RETRY_MAX)) begin
                state <= protect_pkg::BR_LATCHED;
                short_gnd <= high_side;
                short_supply <= !high_side;
              end else begin
                tries <= tries + 2'h1;
                state <= protect_pkg::BR_RETRY;
              end
            end else begin
              cnt <= cnt + 8'h01;
            end
          end else begin
            cnt <= 8'h00;
          end
        end
        protect_pkg::BR_RETRY: begin
          if (cnt >= 8'(protect_pkg::OC_RETRY_WAIT_CYC)) begin
            cnt <= 8'h00;
            state <= protect_pkg::BR_RUN;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          if (recover) begin
            state <= protect_pkg::BR_RUN;
            tries <= 2'h0;
            short_gnd <= 1'b0;
            short_supply <= 1'b0;
          end
        end
      endcase
    end
  end
  assign bridge_off = (state != protect_pkg::BR_RUN);
endmodule : bridge_guard

// >>> rtl/driver_protection_shutdown.sv
// Purpose: Protection and shutdown control for a stepper power stage
// Assumes: APB slave, 20 MHz core clock, analog sense already digitised
// Notes: Bridge enables low switch every transistor off
// Functional notes
// - Disable pin high turns off all bridge transistors.
// - Stop flag with encoder input high halts stepping into hold.
// - Sleep pin low over 30 us causes full chip reset.
// - Sleep pin pulses under 30 us are ignored.
// - Sleep pin held low keeps standby with supplies off.
// - Reset or standby restores defaults and keeps bridges off.
// - Current over limit past blanking trips that bridge at once.
// - Overcurrent limit follows the current range field.
// - Three retries then short flag set and bridge latched off.
// - Registers stay accessible while a bridge is latched.
// - Cycling the disable pin re-enables a latched bridge.
// - Off time zero disables bridges, nonzero re-enables.
// - Overtemperature flag and tristate, auto resume when cool.
// - Temperature sample at or above a nonzero warn threshold raises pre-warning.
// - Temperature sample is 7.7 counts per degree plus 2038.
// - Supply sample readable at 9.732 mV per count.
// - Open-drain output released while supply at or above limit.
// - During overvoltage brake output chops near 3.5 kHz.
// - Limit 5.0 A for 1x, 3.33 A for 01, 1.67 A for 00.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ns
module driver_protection_shutdown (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic driver_off_n,
  input wire logic encoder_a_input,
  input wire logic sleep_reset_n,
  // Sense
  input wire protect_pkg::sense_s sense,
  // Power stage
  output logic bridge_a_en,
  output logic bridge_b_en,
  output logic step_halt,
  output logic standby,
  output logic chip_reset_out,
  // Brake open drain
  output logic brake_switch_out,
  output logic brake_switch_oe,
  // Status
  output logic overtemp_flag,
  output logic thermal_warn
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic drv_s1;
  logic drv_s2;
  logic enc_s1;
  logic enc_s2;
  logic drv_prev;
  logic chip_reset;
  logic soft_rst_n;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      drv_s1 <= 1'b1;
      drv_s2 <= 1'b1;
      enc_s1 <= 1'b0;
      enc_s2 <= 1'b0;
      drv_prev <= 1'b1;
    end else if (clk_en) begin
      drv_s1 <= driver_off_n;
      drv_s2 <= drv_s1;
      enc_s1 <= encoder_a_input;
      enc_s2 <= enc_s1;
      drv_prev <= drv_s2;
    end
  end
  sleep_filter u_sleep (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .sleep_reset_n(sleep_reset_n),
    .chip_reset(chip_reset)
  );
  assign soft_rst_n = rst_n && !chip_reset;
  assign chip_reset_out = chip_reset;
  assign standby = chip_reset;
  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] global_config_reg;
  logic [31:0] driver_config_reg;
  logic [31:0] chopper_config_reg;
  logic [31:0] thermal_supply_limit_reg;
  logic wr_en;
  logic rd_en;
  logic bad_addr;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  always_comb begin
    if (paddr == protect_pkg::GLOBAL_CONFIG_OFS) begin
      bad_addr = 1'b0;
    end else if (paddr == protect_pkg::DRIVER_CONFIG_OFS) begin
      bad_addr = 1'b0;
    end else if (paddr == protect_pkg::CHOPPER_CONFIG_OFS) begin
      bad_addr = 1'b0;
    end else if (paddr == protect_pkg::THERMAL_LIMIT_OFS) begin
      bad_addr = 1'b0;
    end else if (paddr == protect_pkg::DRIVER_STATUS_OFS) begin
      bad_addr = 1'b0;
    end else if (paddr == protect_pkg::SUPPLY_SAMPLE_OFS) begin
      bad_addr = 1'b0;
    end else if (paddr == protect_pkg::TEMP_SAMPLE_OFS) begin
      bad_addr = 1'b0;
    end else begin
      bad_addr = 1'b1;
    end
  end
  assign pslverr = psel && penable && bad_addr;
  always_ff @(posedge core_clk) begin
    if (!soft_rst_n) begin
      global_config_reg <= protect_pkg::GLOBAL_CONFIG_RST;
      driver_config_reg <= protect_pkg::DRIVER_CONFIG_RST;
      chopper_config_reg <= protect_pkg::CHOPPER_CONFIG_RST;
      thermal_supply_limit_reg <= protect_pkg::THERMAL_LIMIT_RST;
    end else if (clk_en && wr_en) begin
      if (paddr == protect_pkg::GLOBAL_CONFIG_OFS) begin
        global_config_reg <= pwdata;
      end else if (paddr == protect_pkg::DRIVER_CONFIG_OFS) begin
        driver_config_reg <= pwdata;
      end else if (paddr == protect_pkg::CHOPPER_CONFIG_OFS) begin
        chopper_config_reg <= pwdata;
      end else if (paddr == protect_pkg::THERMAL_LIMIT_OFS) begin
        thermal_supply_limit_reg <= pwdata;
      end
    end
  end
  // ****************************************
  // Fields
  // ****************************************
  logic stop_enable;
  logic [1:0] current_range;
  logic [3:0] chopper_off_time;
  logic [12:0] supply_limit_threshold;
  logic [12:0] thermal_warn_threshold;
  logic [12:0] oc_limit;
  assign stop_enable = global_config_reg[protect_pkg::STOP_ENABLE_BIT];
  assign current_range = driver_config_reg[protect_pkg::RANGE_LSB +: 2];
  assign chopper_off_time =
    chopper_config_reg[protect_pkg::OFF_TIME_LSB +: 4];
  assign supply_limit_threshold =
    thermal_supply_limit_reg[protect_pkg::SUPPLY_LIM_LSB +: 13];
  assign thermal_warn_threshold =
    thermal_supply_limit_reg[protect_pkg::WARN_LIM_LSB +: 13];
  always_comb begin
    case (current_range)
      2'b00: oc_limit = protect_pkg::OC_LIM_00;
      2'b01: oc_limit = protect_pkg::OC_LIM_01;
      default: oc_limit = protect_pkg::OC_LIM_1X;
    endcase
  end
  // ****************************************
  // Recovery
  // ****************************************
  logic off_time_prev;
  logic recover;
  always_ff @(posedge core_clk) begin
    if (!soft_rst_n) begin
      off_time_prev <= 1'b0;
    end else if (clk_en) begin
      off_time_prev <= (chopper_off_time != 4'h0);
    end
  end
  assign recover = (drv_s2 && !drv_prev) ||
    ((chopper_off_time != 4'h0) && !off_time_prev);
  // ****************************************
  // Overcurrent guards
  // ****************************************
  logic off_a;
  logic off_b;
  logic short_gnd_bridge_a;
  logic short_gnd_bridge_b;
  logic short_supply_bridge_a;
  logic short_supply_bridge_b;
  bridge_guard u_guard_a (
    .core_clk(core_clk),
    .rst_n(soft_rst_n),
    .clk_en(clk_en),
    .current(sense.current_a),
    .high_side(1'b1),
    .limit(oc_limit),
    .recover(recover),
    .bridge_off(off_a),
    .short_gnd(short_gnd_bridge_a),
    .short_supply(short_supply_bridge_a)
  );
  bridge_guard u_guard_b (
    .core_clk(core_clk),
    .rst_n(soft_rst_n),
    .clk_en(clk_en),
    .current(sense.current_b),
    .high_side(1'b1),
    .limit(oc_limit),
    .recover(recover),
    .bridge_off(off_b),
    .short_gnd(short_gnd_bridge_b),
    .short_supply(short_supply_bridge_b)
  );
  // ****************************************
  // Thermal
  // ****************************************
  // hysteresis shutdown
  always_ff @(posedge core_clk) begin
    if (!soft_rst_n) begin
      overtemp_flag <= 1'b0;
    end else if (clk_en) begin
      if (sense.die_hot) begin
        overtemp_flag <= 1'b1;
      end else if (sense.die_cool) begin
        overtemp_flag <= 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!soft_rst_n) begin
      thermal_warn <= 1'b0;
    end else if (clk_en) begin
      thermal_warn <= (sense.temp_adc >= thermal_warn_threshold) &&
        (thermal_warn_threshold != 13'h0000);
    end
  end
  // ****************************************
  // Bridge enables and stop
  // ****************************************
  logic all_on;
  assign all_on = !drv_s2 && !chip_reset && (chopper_off_time != 4'h0) &&
    !overtemp_flag;
  always_ff @(posedge core_clk) begin
    if (!soft_rst_n) begin
      bridge_a_en <= 1'b0;
      bridge_b_en <= 1'b0;
      step_halt <= 1'b0;
    end else if (clk_en) begin
      bridge_a_en <= all_on && !off_a;
      bridge_b_en <= all_on && !off_b;
      step_halt <= stop_enable && enc_s2;
    end
  end
  // ****************************************
  // Overvoltage brake
  // ****************************************
  logic overvolt;
  logic [11:0] chop_cnt;
  logic chop_phase;
  assign overvolt = (sense.supply_adc >= supply_limit_threshold);
  always_ff @(posedge core_clk) begin
    if (!soft_rst_n) begin
      chop_cnt <= 12'h000;
      chop_phase <= 1'b0;
    end else if (clk_en) begin
      if (!overvolt) begin
        chop_cnt <= 12'h000;
        chop_phase <= 1'b0;
      end else if (chop_cnt >= 12'(protect_pkg::BRAKE_HALF_CYC - 1)) begin
        chop_cnt <= 12'h000;
        chop_phase <= !chop_phase;
      end else begin
        chop_cnt <= chop_cnt + 12'h001;
      end
    end
  end
  // Low drive pulls brake off; released phase turns transistor on
  assign brake_switch_out = 1'b0;
  assign brake_switch_oe = !(overvolt && !chop_phase);
  // ****************************************
  // Read path
  // ****************************************
  // register, status, supply and temperature readout
  always_ff @(posedge core_clk) begin
    if (!soft_rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && rd_en) begin
      if (paddr == protect_pkg::GLOBAL_CONFIG_OFS) begin
        prdata <= global_config_reg;
      end else if (paddr == protect_pkg::DRIVER_CONFIG_OFS) begin
        prdata <= driver_config_reg;
      end else if (paddr == protect_pkg::CHOPPER_CONFIG_OFS) begin
        prdata <= chopper_config_reg;
      end else if (paddr == protect_pkg::THERMAL_LIMIT_OFS) begin
        prdata <= thermal_supply_limit_reg;
      end else if (paddr == protect_pkg::DRIVER_STATUS_OFS) begin
        prdata <= {24'h000000, thermal_warn, overtemp_flag, off_b, off_a,
          short_supply_bridge_b, short_supply_bridge_a,
          short_gnd_bridge_b, short_gnd_bridge_a};
      end else if (paddr == protect_pkg::SUPPLY_SAMPLE_OFS) begin
        prdata <= {19'h00000, sense.supply_adc};
      end else if (paddr == protect_pkg::TEMP_SAMPLE_OFS) begin
        prdata <= {19'h00000, sense.temp_adc};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  a_disable_pin_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && drv_s2 |=> !bridge_a_en && !bridge_b_en)
    else $error("bridge on while disable pin high");
  a_stop_halts: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && stop_enable && enc_s2 && !chip_reset |=> step_halt)
    else $error("stop input did not halt");
  a_reset_bridges_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    chip_reset |=> !bridge_a_en && !bridge_b_en && chopper_off_time == 4'h0)
    else $error("bridges allowed during reset");
  a_off_time_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && chopper_off_time == 4'h0 |=> !bridge_a_en && !bridge_b_en)
    else $error("bridge on with zero off time");
  a_overtemp_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && overtemp_flag |=> !bridge_a_en)
    else $error("bridge on while overheated");
  a_range_limit: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    current_range[1] |-> oc_limit == protect_pkg::OC_LIM_1X)
    else $error("wrong high range limit");
  a_brake_release: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !overvolt |-> brake_switch_oe)
    else $error("brake driven without overvoltage");
  a_latched_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && short_gnd_bridge_a |=> !bridge_a_en)
    else $error("latched bridge still on");
endmodule : driver_protection_shutdown

// >>> testbench/power_stage_model.sv
// Purpose: Coils, brake transistor and sensors around the block
// Assumes: Test bench sets fault conditions
// Notes: Brake node has a pull-up
`timescale 1ns/1ns
module power_stage_model (
  // Bridge side
  input wire logic bridge_a_en,
  input wire logic bridge_b_en,
  input wire logic brake_switch_out,
  input wire logic brake_switch_oe,
  // Conditions
  input wire logic short_a,
  input wire logic [12:0] short_ma,
  input wire logic die_hot,
  input wire logic die_cool,
  input wire logic [12:0] supply_adc,
  input wire logic [12:0] temp_adc,
  // Sensed values
  output protect_pkg::sense_s sense,
  output logic brake_line
);
  always_comb begin
    sense.current_a = !bridge_a_en ? 13'h0000 : short_a ? short_ma : 13'h0200;
    sense.current_b = bridge_b_en ? 13'h0200 : 13'h0000;
    sense.die_hot = die_hot;
    sense.die_cool = die_cool;
    sense.supply_adc = supply_adc;
    sense.temp_adc = temp_adc;
  end
  assign brake_line = brake_switch_oe ? brake_switch_out : 1'b1;
endmodule : power_stage_model

// >>> testbench/driver_protection_shutdown_tb.sv
// Purpose: Self-checking bench for the protection block
// Assumes: APB master, 50 ns clock
// Notes: Expected values derived from the package
`timescale 1ns/1ns
module driver_protection_shutdown_tb;
  logic core_clk = 0, rst_n = 0, clk_en = 1;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, brake_line, brake_out, brake_oe;
  logic driver_off_n = 1, encoder_a_input = 0, sleep_reset_n = 1;
  logic bridge_a_en, bridge_b_en, step_halt, standby, chip_reset_out;
  logic overtemp_flag, thermal_warn, short_a = 0, die_hot = 0, die_cool = 1;
  logic [12:0] short_ma = 13'h0000, supply = 13'h0800, temp = 13'h0800;
  logic [31:0] rd;
  logic err;
  protect_pkg::sense_s sense;
  int n_errors = 0, compares = 0;

  initial forever #25 core_clk = ~core_clk;

  driver_protection_shutdown driver_protection_shutdown_i (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .driver_off_n(driver_off_n), .encoder_a_input(encoder_a_input),
    .sleep_reset_n(sleep_reset_n), .sense(sense),
    .bridge_a_en(bridge_a_en), .bridge_b_en(bridge_b_en),
    .step_halt(step_halt), .standby(standby),
    .chip_reset_out(chip_reset_out), .brake_switch_out(brake_out),
    .brake_switch_oe(brake_oe), .overtemp_flag(overtemp_flag),
    .thermal_warn(thermal_warn)
  );
  power_stage_model power_stage_model_i (
    .bridge_a_en(bridge_a_en), .bridge_b_en(bridge_b_en),
    .brake_switch_out(brake_out), .brake_switch_oe(brake_oe),
    .short_a(short_a), .short_ma(short_ma), .die_hot(die_hot),
    .die_cool(die_cool), .supply_adc(supply), .temp_adc(temp),
    .sense(sense), .brake_line(brake_line)
  );

  task complete_run;
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    err = pslverr;
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask : apb

  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
              input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd & m, exp);
  endtask : rd_chk

  initial begin
    tick(20000);
    n_errors++;
    complete_run();
  end

  initial begin
    tick(16);
    rst_n <= 1;
    rd_chk("global", protect_pkg::GLOBAL_CONFIG_OFS, '1, 32'h0);
    rd_chk("chopper", protect_pkg::CHOPPER_CONFIG_OFS, '1, 32'h0);
    rd_chk("limits", protect_pkg::THERMAL_LIMIT_OFS, '1, 32'h0);
    check("mapped", {rd[30:0], err}, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, protect_pkg::THERMAL_LIMIT_OFS, 32'h0A00_0C00);
    apb(1'b1, protect_pkg::CHOPPER_CONFIG_OFS, 32'h5);
    tick(4);
    check("disabled", {bridge_a_en, bridge_b_en}, 2'b00);
    driver_off_n <= 0;
    tick(4);
    check("enabled", {bridge_a_en, bridge_b_en}, 2'b11);
    driver_off_n <= 1;
    tick(4);
    check("pin off", {bridge_a_en, bridge_b_en}, 2'b00);
    clk_en <= 0;
    driver_off_n <= 0;
    tick(4);
    check("frozen", {bridge_a_en, bridge_b_en}, 2'b00);
    clk_en <= 1;
    apb(1'b1, protect_pkg::GLOBAL_CONFIG_OFS, 32'h1);
    encoder_a_input <= 1;
    tick(4);
    check("halt", step_halt, 1'b1);
    encoder_a_input <= 0;
    tick(4);
    check("run", step_halt, 1'b0);
    supply <= 13'h0BFF;
    tick(4);
    check("below", brake_line, 1'b0);
    rd_chk("supply", protect_pkg::SUPPLY_SAMPLE_OFS, 32'h1FFF, 32'h0BFF);
    supply <= 13'h0C00;
    tick(4);
    check("at lim", brake_line, 1'b1);
    tick(protect_pkg::BRAKE_HALF_CYC);
    check("chop", brake_line, 1'b0);
    supply <= 13'h0800;
    temp <= 13'(protect_pkg::TEMP_OFFSET + protect_pkg::TEMP_SCALE_X10 * 5);
    tick(4);
    rd_chk("temp", protect_pkg::TEMP_SAMPLE_OFS, 32'h1FFF, 32'h0977);
    check("no warn", thermal_warn, 1'b0);
    temp <= 13'h0A01;
    tick(4);
    check("warn", thermal_warn, 1'b1);
    temp <= 13'h0800;
    die_hot <= 1;
    die_cool <= 0;
    tick(4);
    check("hot", {overtemp_flag, bridge_a_en, bridge_b_en}, 3'b100);
    die_hot <= 0;
    tick(4);
    check("warm", {overtemp_flag, bridge_a_en, bridge_b_en}, 3'b100);
    die_cool <= 1;
    tick(4);
    check("cool", {overtemp_flag, bridge_a_en, bridge_b_en}, 3'b011);
    // range 01 tolerates current above 00 limit
    apb(1'b1, protect_pkg::DRIVER_CONFIG_OFS, 32'h1);
    short_ma <= protect_pkg::OC_LIM_00 + 13'h0010;
    short_a <= 1;
    tick(1500);
    rd_chk("range01", protect_pkg::DRIVER_STATUS_OFS, 32'hFF, 32'h0);
    apb(1'b1, protect_pkg::DRIVER_CONFIG_OFS, 32'h0);
    tick(1500);
    rd_chk("latched", protect_pkg::DRIVER_STATUS_OFS, 32'hFF, 32'h11);
    check("bridges", {bridge_a_en, bridge_b_en}, 2'b01);
    apb(1'b1, protect_pkg::DRIVER_CONFIG_OFS, 32'h2);
    rd_chk("cfg", protect_pkg::DRIVER_CONFIG_OFS, 32'h3, 32'h2);
    short_a <= 0;
    driver_off_n <= 1;
    tick(4);
    driver_off_n <= 0;
    tick(4);
    check("pin rec", bridge_a_en, 1'b1);
    rd_chk("cleared", protect_pkg::DRIVER_STATUS_OFS, 32'hFF, 32'h0);
    // code 10 trips above full limit
    short_ma <= protect_pkg::OC_LIM_1X + 13'h0008;
    short_a <= 1;
    tick(1500);
    rd_chk("trip10", protect_pkg::DRIVER_STATUS_OFS, 32'h11, 32'h11);
    apb(1'b1, protect_pkg::CHOPPER_CONFIG_OFS, 32'h0);
    short_a <= 0;
    tick(4);
    check("toff0", {bridge_a_en, bridge_b_en}, 2'b00);
    apb(1'b1, protect_pkg::CHOPPER_CONFIG_OFS, 32'h5);
    tick(4);
    check("toff5", {bridge_a_en, bridge_b_en}, 2'b11);
    rd_chk("clr2", protect_pkg::DRIVER_STATUS_OFS, 32'hFF, 32'h0);
    sleep_reset_n <= 0;
    tick(500);
    check("short", {chip_reset_out, standby}, 2'b00);
    sleep_reset_n <= 1;
    tick(4);
    rd_chk("kept", protect_pkg::GLOBAL_CONFIG_OFS, '1, 32'h1);
    sleep_reset_n <= 0;
    tick(700);
    check("long", {chip_reset_out, standby}, 2'b11);
    check("sleep br", {bridge_a_en, bridge_b_en}, 2'b00);
    sleep_reset_n <= 1;
    tick(10);
    rd_chk("gone", protect_pkg::CHOPPER_CONFIG_OFS, '1, 32'h0);
    check("off", {bridge_a_en, bridge_b_en}, 2'b00);
    complete_run();
  end
endmodule : driver_protection_shutdown_tb
